// ==== hw/lpms_top.sv ====
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
// Contract
// - peripherals get their clocks automatically in sleep levels 0..4, not in core-off
// - sub-main request raises level 2 to 0, levels 3 and 4 to 1
// - aux-only request turns level 4 into 3; no request keeps level
// - enabled interrupt wakes from levels 0..4 and starts service
// - service entry pushes program counter and status word
// - service entry clears halt, oscillator disable and sub-main gate bits
// - return pops the saved status word, restoring previous level
// - altered stacked bits are applied on return
// - core-off entry disables core regulator, contents lost
// - every core-off exit gives brownout reset, boot runs first
// - deep core-off stops all clocks; shallow keeps rtc mode
// - shallow core-off also accepts rtc wakeup
// - core-off exit by reset pin, power-on or wake pins
// - after boot, execution resumes at reset vector
// - core-off wakeup sets the deep sleep wake flag
// - reset cause reads 08h after core-off wakeup
// - i/o held through core-off until software clears lock
// - rtc keeps running across shallow core-off wakeup and reset
// - gate bits in status word encode the sleep levels
// - core-off only from level-4 bits with regulator-off request set
module lpms_top (
   input wire logic ref_clk_i, // system clock, 40 MHz
   input wire logic arst_n_i, // async reset, active low
   input wire logic psel_i, // apb select
   input wire logic penable_i, // apb enable
   input wire logic pwrite_i, // apb direction
   input wire logic [11:0] paddr_i, // apb byte address
   input wire logic [31:0] pwdata_i, // apb write data
   output logic [31:0] prdata_o, // apb read data
   output logic pready_o, // apb ready
   output logic pslverr_o, // apb error, unmapped address
   input wire logic psw_wr_i, // core writes status word
   input wire logic [15:0] psw_wdata_i, // new status word
   input wire logic [15:0] pc_i, // current program counter
   input wire logic irq_i, // enabled interrupt pending
   input wire logic return_from_interrupt_i, // return from interrupt
   input wire logic [15:0] pop_psw_i, // status word popped from stack
   input wire logic aux_clk_req_i, // peripheral aux clock request
   input wire logic sub_clk_req_i, // peripheral sub-main clock request
   input wire logic reset_pin_i, // reset pin event
   input wire logic power_on_i, // power-on cycle
   input wire logic io_wake_i, // wake-capable pin event
   input wire logic rtc_wake_i, // rtc wakeup event
   input wire logic boot_done_i, // boot code finished
   output logic [15:0] psw_o, // live status word
   output logic irq_ack_o, // service entry pulse
   output logic stack_push_o, // push pulse
   output logic [15:0] stack_pc_o, // pushed program counter
   output logic [15:0] stack_psw_o, // pushed status word
   output logic fetch_en_o, // instruction fetch allowed
   output logic main_clk_en_o, // processor clock enable
   output logic aux_clk_en_o, // aux clock enable
   output logic sub_clk_en_o, // sub-main clock enable
   output logic [2:0] level_o, // effective level code
   output logic core_reg_en_o, // core regulator enable
   output logic io_hold_o, // i/o pin states held
   output logic rtc_run_o, // rtc powered and running
   output logic bor_o, // brownout reset to the system
   output logic boot_run_o, // boot code phase
   output logic resume_o, // start fetch at vector, pulse
   output logic [15:0] resume_vec_o // resume address
);
   ////////////////////////////////////////////////////////////////////
   lpms_pkg::lpms_state_type st_ff;
   lpms_pkg::lpms_state_type nxt_st;
   lpms_pkg::lpms_level_type req_lv;
   lpms_pkg::lpms_level_type eff_lv;
   logic [15:0] psw_ff;
   logic [6:0] bor_cnt_ff;
   logic irq_ack_ff;
   logic push_ff;
   logic [15:0] stack_pc_ff;
   logic [15:0] stack_psw_ff;
   logic resume_ff;
   logic lock_ff;
   logic regoff_ff;
   logic rtc_keep_ff;
   logic flag_ff;
   logic [7:0] cause_ff;
   logic [31:0] prdata_ff;
   logic [2:0] level_ff;
   logic [2:0] clk_en_ff;
   logic irq_take;
   logic off_go;
   logic wake;
   logic acc;
   logic wr_ctrl;
   logic wr_stat;
   logic rd_cause;
   logic hit;

   lpms_level_resolve u_resolve (
      .halt_i(psw_ff[lpms_pkg::HALT_POS]),
      .osc_i(psw_ff[lpms_pkg::OSC_POS]),
      .gen_i(psw_ff[lpms_pkg::GEN_POS]),
      .sub_i(psw_ff[lpms_pkg::SUB_POS]),
      .aux_req_i(aux_clk_req_i),
      .sub_req_i(sub_clk_req_i),
      .req_o(req_lv),
      .eff_o(eff_lv)
   );

   ////////////////////////////////////////////////////////////////////
   // ack blocks a take only in the cycle after each entry; a level held longer is taken again every other cycle
   assign irq_take = (st_ff == lpms_pkg::ST_RUN) && irq_i
                     && psw_ff[lpms_pkg::GIE_POS] && !irq_ack_ff;
   assign off_go = (st_ff == lpms_pkg::ST_RUN) && !irq_take && regoff_ff
                   && (req_lv == lpms_pkg::LV_FOUR);
   assign wake = reset_pin_i || power_on_i || io_wake_i
                 || (rtc_keep_ff && rtc_wake_i);

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         psw_ff <= lpms_pkg::PSW_RST;
      end else if (st_ff != lpms_pkg::ST_RUN) begin
         psw_ff <= lpms_pkg::PSW_RST;
      end else if (irq_take) begin
         psw_ff[lpms_pkg::HALT_POS] <= 1'b0;
         psw_ff[lpms_pkg::OSC_POS] <= 1'b0;
         psw_ff[lpms_pkg::SUB_POS] <= 1'b0;
      end else if (return_from_interrupt_i) begin
         psw_ff <= pop_psw_i;
      end else if (psw_wr_i) begin
         psw_ff <= psw_wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_ack_ff <= 1'b0;
         push_ff <= 1'b0;
         stack_pc_ff <= 16'h0000;
         stack_psw_ff <= 16'h0000;
      end else begin
         irq_ack_ff <= irq_take;
         push_ff <= irq_take;
         if (irq_take) begin
            stack_pc_ff <= pc_i;
            stack_psw_ff <= psw_ff;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_st = st_ff;
      unique case (st_ff)
         lpms_pkg::ST_RUN: if (off_go) nxt_st = lpms_pkg::ST_OFF;
         lpms_pkg::ST_OFF: if (wake) nxt_st = lpms_pkg::ST_BOR;
         lpms_pkg::ST_BOR: if (bor_cnt_ff == lpms_pkg::BOR_LAST) nxt_st = lpms_pkg::ST_BOOT;
         lpms_pkg::ST_BOOT: if (boot_done_i) nxt_st = lpms_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_ff <= lpms_pkg::ST_RUN;
      end else begin
         st_ff <= nxt_st;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bor_cnt_ff <= 7'h00;
      end else if (st_ff == lpms_pkg::ST_BOR) begin
         bor_cnt_ff <= bor_cnt_ff + 7'h01;
      end else begin
         bor_cnt_ff <= 7'h00;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         resume_ff <= 1'b0;
      end else begin
         resume_ff <= (st_ff == lpms_pkg::ST_BOOT) && boot_done_i;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // clock enables follow the resolved level so requests are served in levels 0..4; core-off clears them all
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clk_en_ff <= 3'h7;
         level_ff <= lpms_pkg::LV_ACTIVE;
      end else if (st_ff == lpms_pkg::ST_RUN && !off_go) begin
         clk_en_ff[0] <= (eff_lv == lpms_pkg::LV_ACTIVE);
         clk_en_ff[1] <= (eff_lv != lpms_pkg::LV_FOUR);
         clk_en_ff[2] <= (eff_lv == lpms_pkg::LV_ACTIVE) || (eff_lv == lpms_pkg::LV_ZERO)
                         || (eff_lv == lpms_pkg::LV_ONE);
         level_ff <= eff_lv;
      end else if (st_ff == lpms_pkg::ST_RUN || st_ff == lpms_pkg::ST_OFF) begin
         clk_en_ff <= 3'h0;
         level_ff <= rtc_keep_ff ? lpms_pkg::LV_OFF_RTC : lpms_pkg::LV_OFF_DEEP;
      end else begin
         clk_en_ff <= 3'h7;
         level_ff <= lpms_pkg::LV_ACTIVE;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // apb: zero wait states, read data captured in setup phase
   assign acc = psel_i && penable_i;
   assign hit = (paddr_i == lpms_pkg::OFS_CTRL) || (paddr_i == lpms_pkg::OFS_STAT)
                || (paddr_i == lpms_pkg::OFS_CAUSE);
   assign wr_ctrl = acc && pwrite_i && (paddr_i == lpms_pkg::OFS_CTRL);
   assign wr_stat = acc && pwrite_i && (paddr_i == lpms_pkg::OFS_STAT);
   assign rd_cause = acc && !pwrite_i && (paddr_i == lpms_pkg::OFS_CAUSE);

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel_i && !penable_i) begin
         prdata_ff <= 32'h0000_0000;
         unique case (paddr_i)
            lpms_pkg::OFS_CTRL: begin
               prdata_ff[lpms_pkg::LOCK_POS] <= lock_ff;
               prdata_ff[lpms_pkg::REGOFF_POS] <= regoff_ff;
               prdata_ff[lpms_pkg::RTC_POS] <= rtc_keep_ff;
            end
            lpms_pkg::OFS_STAT: begin
               prdata_ff[lpms_pkg::FLAG_POS] <= flag_ff;
               prdata_ff[3:1] <= level_ff;
               prdata_ff[5:4] <= st_ff;
            end
            lpms_pkg::OFS_CAUSE: prdata_ff[7:0] <= cause_ff;
            default: prdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // lock, regulator-off request and rtc keep live in the always-on domain
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lock_ff <= 1'b0;
      end else if (off_go) begin
         lock_ff <= 1'b1;
      end else if (wr_ctrl) begin
         lock_ff <= pwdata_i[lpms_pkg::LOCK_POS];
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         regoff_ff <= 1'b0;
      end else if (st_ff == lpms_pkg::ST_BOR) begin
         regoff_ff <= 1'b0; // avoids dropping straight back into core-off
      end else if (wr_ctrl) begin
         regoff_ff <= pwdata_i[lpms_pkg::REGOFF_POS];
      end
   end

   // not touched by the brownout, so rtc survives the wakeup
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rtc_keep_ff <= 1'b0;
      end else if (wr_ctrl && st_ff == lpms_pkg::ST_RUN) begin
         rtc_keep_ff <= pwdata_i[lpms_pkg::RTC_POS];
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flag_ff <= 1'b0;
      end else if (st_ff == lpms_pkg::ST_OFF && wake) begin
         flag_ff <= 1'b1;
      end else if (wr_stat && pwdata_i[lpms_pkg::FLAG_POS]) begin
         flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cause_ff <= lpms_pkg::CAUSE_NONE;
      end else if (st_ff == lpms_pkg::ST_OFF && wake) begin
         cause_ff <= lpms_pkg::CAUSE_CORE_OFF;
      end else if (rd_cause) begin
         cause_ff <= lpms_pkg::CAUSE_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign prdata_o = prdata_ff;
   assign pready_o = 1'b1;
   assign pslverr_o = acc && !hit;
   assign psw_o = psw_ff;
   assign irq_ack_o = irq_ack_ff;
   assign stack_push_o = push_ff;
   assign stack_pc_o = stack_pc_ff;
   assign stack_psw_o = stack_psw_ff;
   assign fetch_en_o = (st_ff == lpms_pkg::ST_RUN) && !psw_ff[lpms_pkg::HALT_POS];
   assign main_clk_en_o = clk_en_ff[0];
   assign aux_clk_en_o = clk_en_ff[1];
   assign sub_clk_en_o = clk_en_ff[2];
   assign level_o = level_ff;
   assign core_reg_en_o = (st_ff != lpms_pkg::ST_OFF);
   assign io_hold_o = lock_ff;
   assign rtc_run_o = rtc_keep_ff;
   assign bor_o = (st_ff == lpms_pkg::ST_BOR);
   assign boot_run_o = (st_ff == lpms_pkg::ST_BOOT);
   assign resume_o = resume_ff;
   assign resume_vec_o = lpms_pkg::RESET_VEC;

   ////////////////////////////////////////////////////////////////////
   property p_sub_raise;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      sub_clk_req_i && req_lv == lpms_pkg::LV_TWO |-> eff_lv == lpms_pkg::LV_ZERO;
   endproperty
   a_sub_raise: assert property (p_sub_raise) else $error("level 2 not raised");

   property p_aux_raise;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      aux_clk_req_i && !sub_clk_req_i && req_lv == lpms_pkg::LV_FOUR
      |-> eff_lv == lpms_pkg::LV_THREE;
   endproperty
   a_aux_raise: assert property (p_aux_raise) else $error("level 4 not raised");

   property p_wake;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      irq_take && psw_ff[lpms_pkg::HALT_POS] |=> irq_ack_o && fetch_en_o;
   endproperty
   a_wake: assert property (p_wake) else $error("interrupt did not wake");

   property p_push;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      irq_take |=> stack_push_o && stack_psw_o == $past(psw_ff) && stack_pc_o == $past(pc_i);
   endproperty
   a_push: assert property (p_push) else $error("push data wrong");

   property p_clear;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      irq_take |=> !psw_o[lpms_pkg::HALT_POS] && !psw_o[lpms_pkg::OSC_POS]
                   && !psw_o[lpms_pkg::SUB_POS];
   endproperty
   a_clear: assert property (p_clear) else $error("entry bits not cleared");

   property p_pop;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      return_from_interrupt_i && !irq_take && st_ff == lpms_pkg::ST_RUN |=> psw_o == $past(pop_psw_i);
   endproperty
   a_pop: assert property (p_pop) else $error("popped word not applied");

   property p_off;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      off_go |=> !core_reg_en_o && io_hold_o && !main_clk_en_o && !aux_clk_en_o;
   endproperty
   a_off: assert property (p_off) else $error("core-off entry wrong");

   property p_bor;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      st_ff == lpms_pkg::ST_OFF && wake |=> bor_o [*8] ##1 !fetch_en_o;
   endproperty
   a_bor: assert property (p_bor) else $error("no brownout on exit");

   property p_rtc_only;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      st_ff == lpms_pkg::ST_OFF && !rtc_keep_ff && rtc_wake_i && !reset_pin_i
      && !power_on_i && !io_wake_i |=> st_ff == lpms_pkg::ST_OFF;
   endproperty
   a_rtc_only: assert property (p_rtc_only) else $error("deep level woke on rtc");

   property p_cause;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      st_ff == lpms_pkg::ST_OFF && wake |=> flag_ff && cause_ff == lpms_pkg::CAUSE_CORE_OFF;
   endproperty
   a_cause: assert property (p_cause) else $error("wake flag or cause missing");

   property p_halt;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      psw_o[lpms_pkg::HALT_POS] && !irq_take && !return_from_interrupt_i && !psw_wr_i |=> !fetch_en_o;
   endproperty
   a_halt: assert property (p_halt) else $error("fetch while halted");

   c_irq_wake: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      irq_take && psw_ff[lpms_pkg::HALT_POS]);
   c_core_off: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) off_go);
   c_resume: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) resume_ff);
endmodule

// ==== hw/lpms_pkg.sv ====
package lpms_pkg;
   // status word layout
   localparam int PSW_W = 16;
   localparam int GIE_POS = 3;
   localparam int HALT_POS = 4;
   localparam int OSC_POS = 5;
   localparam int GEN_POS = 6;
   localparam int SUB_POS = 7;
   localparam logic [15:0] PSW_RST = 16'h0000;
   localparam logic [15:0] RESET_VEC = 16'hfffe;

   // apb map
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STAT = 12'h004;
   localparam logic [11:0] OFS_CAUSE = 12'h008;
   localparam int LOCK_POS = 0;
   localparam int REGOFF_POS = 1;
   localparam int RTC_POS = 2;
   localparam int FLAG_POS = 0;
   localparam logic [7:0] CAUSE_CORE_OFF = 8'h08;
   localparam logic [7:0] CAUSE_NONE = 8'h00;

   // brownout hold, least time rounds up
   localparam int CLK_PERIOD_NS = 25;
   localparam int BOR_HOLD_NS = 1000;
   localparam int BOR_CYCLES = (BOR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0] BOR_LAST = 7'(BOR_CYCLES - 1);

   typedef enum logic [2:0] {
      LV_ACTIVE = 3'b000,
      LV_ZERO = 3'b001,
      LV_ONE = 3'b010,
      LV_TWO = 3'b011,
      LV_THREE = 3'b100,
      LV_FOUR = 3'b101,
      LV_OFF_RTC = 3'b110,
      LV_OFF_DEEP = 3'b111
   } lpms_level_type;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_OFF = 2'b01,
      ST_BOR = 2'b10,
      ST_BOOT = 2'b11
   } lpms_state_type;
endpackage

// ==== hw/lpms_level_resolve.sv ====
`timescale 1ns/1ps
module lpms_level_resolve (
   input wire logic halt_i, // processor halt bit
   input wire logic osc_i, // oscillator disable bit
   input wire logic gen_i, // generator gate bit
   input wire logic sub_i, // sub-main gate bit
   input wire logic aux_req_i, // peripheral wants aux clock
   input wire logic sub_req_i, // peripheral wants sub-main clock
   output lpms_pkg::lpms_level_type req_o, // level the bits ask for
   output lpms_pkg::lpms_level_type eff_o // level actually reached
);
   always_comb begin
      if (!halt_i) begin
         req_o = lpms_pkg::LV_ACTIVE;
      end else if (osc_i && gen_i && sub_i) begin
         req_o = lpms_pkg::LV_FOUR;
      end else begin
         // odd combinations with osc set fall back to the gate pattern
         unique case ({sub_i, gen_i})
            2'b00: req_o = lpms_pkg::LV_ZERO;
            2'b01: req_o = lpms_pkg::LV_ONE;
            2'b10: req_o = lpms_pkg::LV_TWO;
            2'b11: req_o = lpms_pkg::LV_THREE;
         endcase
      end
   end

   always_comb begin
      eff_o = req_o;
      if (sub_req_i) begin
         if (req_o == lpms_pkg::LV_TWO) begin
            eff_o = lpms_pkg::LV_ZERO;
         end else if (req_o == lpms_pkg::LV_THREE || req_o == lpms_pkg::LV_FOUR) begin
            eff_o = lpms_pkg::LV_ONE;
         end
      end else if (aux_req_i && req_o == lpms_pkg::LV_FOUR) begin
         eff_o = lpms_pkg::LV_THREE;
      end
   end
endmodule

// ==== dv/lpms_core_model.sv ====
`timescale 1ns/1ps
module lpms_core_model (
   input wire logic clk_i, // system clock
   input wire logic arst_n_i, // async reset, active low
   input wire logic irq_ack_i, // service entry pulse
   input wire logic [15:0] stack_psw_i, // stacked status word
   input wire logic boot_run_i, // boot phase
   input wire logic [15:0] clr_mask_i, // bits the handler clears
   input wire logic [3:0] wait_i, // handler and boot length
   output logic return_from_interrupt_o, // return pulse
   output logic [15:0] pop_psw_o, // popped status word
   output logic boot_done_o // boot finished pulse
);
   logic busy_ff;
   logic [3:0] cnt_ff;
   logic [3:0] boot_cnt_ff;
   ////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy_ff <= 1'b0;
         cnt_ff <= 4'h0;
         return_from_interrupt_o <= 1'b0;
         pop_psw_o <= 16'hffff;
      end else begin
         return_from_interrupt_o <= 1'b0;
         pop_psw_o <= ~pop_psw_o; // not valid outside the return pulse
         if (irq_ack_i) begin
            busy_ff <= 1'b1;
            cnt_ff <= wait_i;
         end else if (busy_ff && cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
         end else if (busy_ff) begin
            busy_ff <= 1'b0;
            return_from_interrupt_o <= 1'b1;
            pop_psw_o <= stack_psw_i & ~clr_mask_i;
         end
      end
   end
   // one done pulse per boot phase, never repeated
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         boot_cnt_ff <= 4'h0;
         boot_done_o <= 1'b0;
      end else begin
         boot_cnt_ff <= boot_run_i ? boot_cnt_ff + 4'h1 : 4'h0;
         boot_done_o <= boot_run_i && boot_cnt_ff == wait_i && !boot_done_o;
      end
   end
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
   logic clk = 0, arst_n = 0, psel = 0, pen = 0, pwr = 0, psw_wr = 0, irq = 0;
   logic aux = 0, sub = 0, rpin = 0, pon = 0, iow = 0, rtcw = 0, pready, perr, return_from_interrupt;
   logic boot_done, ack, push, fetch, mclk, aclk, sclk, creg, hold, rtc, bor, boot, res;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [15:0] psw_wd = 0, pc = 0, mask = 0, pop, psw, spc, spsw, vec;
   logic [2:0] lvl;
   logic [3:0] dly = 0;
   logic [15:0] tab [6] = '{16'h0000, 16'h0010, 16'h0050, 16'h0090, 16'h00d0, 16'h00f0};
   int error_cnt = 0, n_checks = 0, seed = 32'h1604b732, n, e, r;
   always #12.5 clk = ~clk;
   lpms_top lpms_top_i (.ref_clk_i(clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(perr), .psw_wr_i(psw_wr), .psw_wdata_i(psw_wd),
      .pc_i(pc), .irq_i(irq), .return_from_interrupt_i(return_from_interrupt), .pop_psw_i(pop), .aux_clk_req_i(aux),
      .sub_clk_req_i(sub), .reset_pin_i(rpin), .power_on_i(pon), .io_wake_i(iow),
      .rtc_wake_i(rtcw), .boot_done_i(boot_done), .psw_o(psw), .irq_ack_o(ack),
      .stack_push_o(push), .stack_pc_o(spc), .stack_psw_o(spsw), .fetch_en_o(fetch),
      .main_clk_en_o(mclk), .aux_clk_en_o(aclk), .sub_clk_en_o(sclk), .level_o(lvl),
      .core_reg_en_o(creg), .io_hold_o(hold), .rtc_run_o(rtc), .bor_o(bor),
      .boot_run_o(boot), .resume_o(res), .resume_vec_o(vec));
   lpms_core_model lpms_core_model_i (.clk_i(clk), .arst_n_i(arst_n), .irq_ack_i(ack),
      .stack_psw_i(spsw), .boot_run_i(boot), .clr_mask_i(mask), .wait_i(dly),
      .return_from_interrupt_o(return_from_interrupt), .pop_psw_o(pop), .boot_done_o(boot_done));
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1;
      // no wait-state count assumed; only the watchdog ends a stuck access
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = perr ? 32'hdead0000 : prdata; // error folded into the read value
      psel <= 0; pen <= 0;
   endtask
   task automatic wpsw(input logic [15:0] v);
      @(posedge clk);
      psw_wr <= 1; psw_wd <= v;
      @(posedge clk);
      psw_wr <= 0;
   endtask
   // expected resolved level code from table index and clock requests
   function automatic int lv(int i, bit a, bit s);
      if (s) return i == 3 ? 1 : (i >= 4 ? 2 : i);
      if (a && i == 5) return 4;
      return i;
   endfunction
   ////////////////////////////////////////////////////////////
   initial begin
      #(25 * 20000);
      error_cnt++;
      finish_test();
   end
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1;
      apb(0, lpms_pkg::OFS_CTRL, 0); chk(rd, 0);
      apb(0, lpms_pkg::OFS_CAUSE, 0); chk(rd, 0);
      apb(0, 12'h00c, 0); chk(rd, 32'hdead0000);
      for (int i = 0; i < 24; i++) begin
         r = $random(seed); e = {r} % 6;
         @(posedge clk); aux <= r[8]; sub <= r[9];
         wpsw(tab[e]);
         tick(3);
         n = lv(e, aux, sub);
         chk(lvl, n);
         chk({mclk, sclk, aclk}, {n == 0, n <= 2, n != 5});
         chk(fetch, e == 0);
      end
      @(posedge clk); aux <= 0; sub <= 0;
      for (int k = 0; k < 3; k++) begin
         wpsw(k == 0 ? 16'h00d0 : 16'h00d8);
         mask <= k == 2 ? 16'h00d0 : 16'h0000; dly <= k == 2 ? 4'h6 : 4'h0;
         @(posedge clk); irq <= 1; pc <= 16'($random(seed)) & 16'hfffe;
         @(posedge clk); irq <= 0;
         #1;
         chk(ack, k != 0);
         if (k == 0) continue;
         chk(push, 1);
         chk({spc, spsw}, {pc, 16'h00d8});
         chk({psw, fetch}, {16'h0048, 1'b1});
         for (n = 0; n < 20 && return_from_interrupt !== 1'b1; n++) tick(1);
         tick(3);
         chk(psw, 16'h00d8 & ~mask);
         chk(lvl, k == 2 ? 0 : 4);
      end
      wpsw(0);
      for (int k = 0; k < 4; k++) begin
         apb(1, lpms_pkg::OFS_CTRL, k == 3 ? 6 : 2);
         wpsw(16'h00f0);
         tick(2);
         chk({creg, hold, lvl}, {2'b01, k == 3 ? 3'd6 : 3'd7});
         chk({mclk, sclk, aclk, rtc}, k == 3);
         if (k != 3) begin
            @(posedge clk); rtcw <= 1;
            tick(4); chk(creg, 0);
            rtcw <= 0;
         end
         @(posedge clk);
         case (k) 0: rpin <= 1; 1: pon <= 1; 2: iow <= 1; default: rtcw <= 1; endcase
         for (n = 0; n < 20 && bor !== 1'b1; n++) tick(1);
         rpin <= 0; pon <= 0; iow <= 0; rtcw <= 0;
         for (e = 0; e < 100 && bor === 1'b1; e++) begin
            if (k == 3) chk(rtc, 1);
            tick(1);
         end
         chk(e, lpms_pkg::BOR_CYCLES);
         chk(boot, 1);
         for (n = 0; n < 40 && res !== 1'b1; n++) tick(1);
         chk({res, vec, fetch, boot}, {1'b1, lpms_pkg::RESET_VEC, 2'b10});
         apb(0, lpms_pkg::OFS_STAT, 0); chk(rd[0], 1);
         // clear the flag so the next wake must set it again
         apb(1, lpms_pkg::OFS_STAT, 1);
         apb(0, lpms_pkg::OFS_STAT, 0); chk(rd[0], 0);
         apb(0, lpms_pkg::OFS_CAUSE, 0); chk(rd, 32'h08);
         apb(0, lpms_pkg::OFS_CAUSE, 0); chk(rd, 0);
         chk(hold, 1);
         apb(1, lpms_pkg::OFS_CTRL, 0);
         tick(2); chk(hold, 0);
      end
      finish_test();
   end
endmodule
